//--- capture_cfg_pkg.sv
package capture_cfg_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_SRC_STD = 12'h004;
  localparam logic [11:0] OFS_DROP = 12'h008;
  localparam logic [11:0] OFS_E_UPPER = 12'h00C;
  localparam logic [11:0] OFS_E_VSTART = 12'h010;
  localparam logic [11:0] OFS_E_VLINES = 12'h014;
  localparam logic [11:0] OFS_E_HSTART = 12'h018;
  localparam logic [11:0] OFS_E_HPIXELS = 12'h01C;
  localparam logic [11:0] OFS_O_UPPER = 12'h08C;
  localparam logic [11:0] OFS_O_VSTART = 12'h090;
  localparam logic [11:0] OFS_O_VLINES = 12'h094;
  localparam logic [11:0] OFS_O_HSTART = 12'h098;
  localparam logic [11:0] OFS_O_HPIXELS = 12'h09C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SRC_STD = 8'h58;
  localparam logic [7:0] RST_DROP = 8'h00;
  localparam logic [7:0] RST_UPPER = 8'h12;
  localparam logic [7:0] RST_VSTART_LO = 8'h16;
  localparam logic [7:0] RST_VLINES_LO = 8'hE0;
  localparam logic [7:0] RST_HSTART_LO = 8'h78;
  localparam logic [7:0] RST_HPIXELS_LO = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRC_LSB = 5;
  localparam int OSC_LSB = 3;
  localparam int STD_LSB = 0;
  localparam int VS_UP_LSB = 6;
  localparam int VL_UP_LSB = 4;
  localparam int HS_UP_LSB = 2;
  localparam int HP_UP_LSB = 0;
  localparam logic [7:0] VS_UP_MASK = 8'hC0;
  localparam int DROP_UNIT_BIT = 7;
  localparam int DROP_PHASE_BIT = 6;
  localparam int DROP_COUNT_LSB = 0;
  localparam int EVEN_IX = 0;
  localparam int ODD_IX = 1;

  // ----------------------------------------------------------------
  // Codes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_IN3 = 2'h0;
  localparam logic [1:0] SRC_IN2 = 2'h1;
  localparam logic [1:0] SRC_IN0 = 2'h2;
  localparam logic [1:0] SRC_IN1 = 2'h3;
  localparam logic [1:0] OSC_PORT0 = 2'h1;
  localparam logic [1:0] OSC_PORT1 = 2'h2;
  localparam logic [1:0] OSC_AUTO = 2'h3;
  localparam logic [2:0] STD_AUTO = 3'h0;
  localparam logic [2:0] STD_NTSC_M = 3'h1;
  localparam logic [2:0] STD_PAL_BDGHI = 3'h3;
  localparam logic [2:0] STD_PAL_NCOMB = 3'h7;
  localparam logic [6:0] PERIOD_525 = 7'h3C;
  localparam logic [6:0] PERIOD_625 = 7'h32;
  localparam logic [9:0] LINE_SPLIT = 10'h120;
  localparam logic [4:0] RUN_LAST = 5'h1F;
  localparam logic VARIANT_ENHANCED = 1'b1;
endpackage

//--- drop_sched_if.sv
`timescale 1ns/1ns
interface drop_sched_if;
  logic unit_tick;
  logic field_even;
  logic frame_mode;
  logic first_even;
  logic [5:0] count;
  logic long_format;
  logic drop;
  modport ctrl(output unit_tick, field_even, frame_mode, first_even,
    output count, long_format, input drop);
  modport sched(input unit_tick, field_even, frame_mode, first_even,
    input count, long_format, output drop);
endinterface

//--- drop_scheduler.sv
`timescale 1ns/1ns
module drop_scheduler (
  input wire logic clk_i,
  input wire logic reset_i,
  drop_sched_if.sched dsi
);
  import capture_cfg_pkg::*;

  typedef struct packed {
    logic [6:0] acc;
    logic armed;
    logic second;
    logic drop;
  } sched_state_t;

  sched_state_t st_reg;
  sched_state_t st_next;
  logic [6:0] period;
  logic [6:0] sum;

  // ----------------------------------------------------------------
  // Field and frame drop decision
  // ----------------------------------------------------------------
  // Error accumulator spreads drops evenly instead of in bursts
  always_comb begin
    st_next = st_reg;
    period = dsi.long_format ? PERIOD_625 : PERIOD_525; // [RL10]
    sum = st_reg.acc + {1'b0, dsi.count};
    if (reset_i) begin
      st_next = '0;
    end else if (dsi.unit_tick) begin
      if (dsi.count == '0) begin
        st_next = '0; // [RL11]
      end else if (!st_reg.armed) begin
        if (dsi.field_even == dsi.first_even) begin
          st_next.armed = 1'b1; // [RL9]
          // Start as if a drop just wrapped: next one a full spacing later
          st_next.acc = '0;
          st_next.drop = 1'b1;
          st_next.second = 1'b1;
        end
      end else if (dsi.frame_mode && st_reg.second) begin
        st_next.second = 1'b0; // [RL8]
      end else begin
        st_next.second = 1'b1;
        st_next.drop = sum >= period; // [RL21]
        st_next.acc = (sum >= period) ? sum - period : sum;
        if (st_next.acc >= period) begin
          st_next.acc = period - 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  assign dsi.drop = st_reg.drop;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_zero_passes_all: assert property ( // [RL11]
    dsi.unit_tick && dsi.count == '0 |=> !dsi.drop)
    else $error("drop with zero count");
  chk_first_drop_phase: assert property ( // [RL9]
    dsi.unit_tick && !st_reg.armed && dsi.count != '0 &&
    dsi.field_even == dsi.first_even |=> dsi.drop)
    else $error("first aligned field not dropped");
  chk_frame_pair: assert property ( // [RL8]
    dsi.unit_tick && st_reg.armed && dsi.frame_mode && st_reg.second
    && dsi.count != '0 |=> $stable(dsi.drop))
    else $error("frame fields split");
  chk_acc_bounded: assert property ( // [RL21]
    st_reg.armed |-> st_reg.acc < PERIOD_525)
    else $error("accumulator out of range");
endmodule // drop_scheduler

//--- capture_cfg_regs.sv
`timescale 1ns/1ns
//Contract
//(RL1) Software writes zero to reserved bit seven
//(RL2) Source codes 01,10,11 pick inputs 2,0,1
//(RL3) Code 00 picks input 3 on enhanced
//(RL4) Oscillator select decode; auto needs code 11
//(RL5) Standard field decodes seven named standards
//(RL6) Auto standard follows detected line-count flag
//(RL7) Code 111 selects PAL N-combination, enhanced
//(RL8) Drop unit bit: frames or fields
//(RL9) Phase bit picks first dropped field parity
//(RL10) Drop count per 60 or 50 units
//(RL11) Zero drop count passes every field
//(RL12) Upper register packs four two-bit fields
//(RL13) Vertical start upper bits swap even/odd address
//(RL14) Vertical start offset is ten bits
//(RL15) Vertical line count is ten bits
//(RL16) Horizontal start counts pixels from strobe fall
//(RL17) Emit programmed pixel count per line
//(RL18) Even/odd copies follow internal field signal
//(RL19) Line flag changes after 32 equal fields
//(RL20) Data on lowest byte lane only
//(RL21) Spread drops evenly across each period
module capture_cfg_regs #(
  parameter logic ENHANCED = capture_cfg_pkg::VARIANT_ENHANCED
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [3:0] reg_byte_en_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic field_i,
  input wire logic vert_strobe_i,
  input wire logic horiz_strobe_i,
  input wire logic pixel_strobe_i,
  output logic [1:0] selected_video_out_o,
  output logic source_valid_o,
  output logic oscillator_port_0_o,
  output logic oscillator_port_1_o,
  output logic oscillator_auto_o,
  output logic [2:0] standard_o,
  output logic standard_valid_o,
  output logic line_count_flag_o,
  output logic drop_field_o,
  output logic [9:0] vertical_start_offset_o,
  output logic [9:0] vertical_line_count_o,
  output logic [9:0] horizontal_start_offset_o,
  output logic [9:0] horizontal_pixel_count_o,
  output logic active_pixel_o
);
  import capture_cfg_pkg::*;

  typedef struct packed {
    logic [7:0] src_std;
    logic [7:0] drop_ctl;
    logic [1:0][7:0] upper;
    logic [1:0][7:0] vs_lo;
    logic [1:0][7:0] vl_lo;
    logic [1:0][7:0] hs_lo;
    logic [1:0][7:0] hp_lo;
    logic [31:0] rdata;
    logic vs_prev;
    logic hs_prev;
    logic [9:0] line_cnt;
    logic long_flag;
    logic [4:0] run;
    logic [9:0] pix_cnt;
    logic tick;
    logic [1:0] src_idx;
    logic src_ok;
    logic osc0;
    logic osc1;
    logic osc_auto;
    logic [2:0] std;
    logic std_ok;
    logic [9:0] vstart;
    logic [9:0] vlines;
    logic [9:0] hstart;
    logic [9:0] hpixels;
    logic active;
  } cfg_state_t;

  cfg_state_t st_reg;
  cfg_state_t st_next;
  logic wr_lane0;
  logic [9:0] word;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic fi;
  logic is_long;
  logic [10:0] win_end;
  logic [1:0] src_code;
  logic [1:0] osc_code;
  logic [2:0] std_code;

  drop_sched_if dsi ();

  // ----------------------------------------------------------------
  // Register access and video timing
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.rdata = '0;
    word = reg_addr_i[11:2];
    wd = reg_wdata_i[7:0];
    wr_lane0 = reg_write_i && reg_byte_en_i[0]; // [RL20]
    fi = field_i ? 1'(EVEN_IX) : 1'(ODD_IX);
    is_long = st_reg.line_cnt > LINE_SPLIT;
    win_end = {1'b0, st_reg.hstart} + {1'b0, st_reg.hpixels};
    src_code = st_reg.src_std[SRC_LSB +: 2];
    osc_code = st_reg.src_std[OSC_LSB +: 2];
    std_code = st_reg.src_std[STD_LSB +: 3];
    // Write side; bit 7 of the source register is stored as given
    if (wr_lane0) begin
      case (word)
        OFS_SRC_STD[11:2]: st_next.src_std = wd; // [RL1]
        OFS_DROP[11:2]: st_next.drop_ctl = wd;
        // Vertical start upper bits land in the other field's copy
        OFS_E_UPPER[11:2]: begin
          st_next.upper[EVEN_IX] = (st_reg.upper[EVEN_IX] & VS_UP_MASK)
            | (wd & ~VS_UP_MASK); // [RL12]
          st_next.upper[ODD_IX] = (st_reg.upper[ODD_IX] & ~VS_UP_MASK)
            | (wd & VS_UP_MASK); // [RL13]
        end
        OFS_O_UPPER[11:2]: begin
          st_next.upper[ODD_IX] = (st_reg.upper[ODD_IX] & VS_UP_MASK)
            | (wd & ~VS_UP_MASK);
          st_next.upper[EVEN_IX] = (st_reg.upper[EVEN_IX] & ~VS_UP_MASK)
            | (wd & VS_UP_MASK); // [RL13]
        end
        OFS_E_VSTART[11:2]: st_next.vs_lo[EVEN_IX] = wd;
        OFS_O_VSTART[11:2]: st_next.vs_lo[ODD_IX] = wd;
        OFS_E_VLINES[11:2]: st_next.vl_lo[EVEN_IX] = wd;
        OFS_O_VLINES[11:2]: st_next.vl_lo[ODD_IX] = wd;
        OFS_E_HSTART[11:2]: st_next.hs_lo[EVEN_IX] = wd;
        OFS_O_HSTART[11:2]: st_next.hs_lo[ODD_IX] = wd;
        OFS_E_HPIXELS[11:2]: st_next.hp_lo[EVEN_IX] = wd;
        OFS_O_HPIXELS[11:2]: st_next.hp_lo[ODD_IX] = wd;
        default: ;
      endcase
    end
    // Read side; readback of upper bits matches the write address
    case (word)
      OFS_SRC_STD[11:2]: rd_byte = st_reg.src_std;
      OFS_DROP[11:2]: rd_byte = st_reg.drop_ctl;
      OFS_E_UPPER[11:2]: rd_byte = {st_reg.upper[ODD_IX][7:6],
        st_reg.upper[EVEN_IX][5:0]};
      OFS_O_UPPER[11:2]: rd_byte = {st_reg.upper[EVEN_IX][7:6],
        st_reg.upper[ODD_IX][5:0]};
      OFS_E_VSTART[11:2]: rd_byte = st_reg.vs_lo[EVEN_IX];
      OFS_O_VSTART[11:2]: rd_byte = st_reg.vs_lo[ODD_IX];
      OFS_E_VLINES[11:2]: rd_byte = st_reg.vl_lo[EVEN_IX];
      OFS_O_VLINES[11:2]: rd_byte = st_reg.vl_lo[ODD_IX];
      OFS_E_HSTART[11:2]: rd_byte = st_reg.hs_lo[EVEN_IX];
      OFS_O_HSTART[11:2]: rd_byte = st_reg.hs_lo[ODD_IX];
      OFS_E_HPIXELS[11:2]: rd_byte = st_reg.hp_lo[EVEN_IX];
      OFS_O_HPIXELS[11:2]: rd_byte = st_reg.hp_lo[ODD_IX];
      default: rd_byte = 8'h00;
    endcase
    if (reg_read_i) begin
      st_next.rdata = {24'h000000, rd_byte}; // [RL20]
    end
    // Line and pixel counting against the timing strobes
    st_next.vs_prev = vert_strobe_i;
    st_next.hs_prev = horiz_strobe_i;
    if (st_reg.hs_prev && !horiz_strobe_i) begin
      st_next.pix_cnt = '0; // [RL16]
      st_next.line_cnt = st_reg.line_cnt + 10'h001;
    end else if (pixel_strobe_i) begin
      st_next.pix_cnt = st_reg.pix_cnt + 10'h001;
    end
    // Field end: classify line count, flag moves after a full run
    if (st_reg.vs_prev && !vert_strobe_i) begin
      st_next.tick = 1'b1;
      st_next.line_cnt = '0;
      if (is_long == st_reg.long_flag) begin
        st_next.run = '0;
      end else if (st_reg.run == RUN_LAST) begin
        st_next.long_flag = is_long; // [RL19]
        st_next.run = '0;
      end else begin
        st_next.run = st_reg.run + 5'h01;
      end
    end
    // Input source decode
    st_next.src_ok = 1'b1;
    case (src_code)
      SRC_IN2: st_next.src_idx = 2'h2; // [RL2]
      SRC_IN0: st_next.src_idx = 2'h0;
      SRC_IN1: st_next.src_idx = 2'h1;
      default: begin
        st_next.src_idx = 2'h3; // [RL3]
        st_next.src_ok = ENHANCED;
      end
    endcase
    // Oscillator decode; reserved code falls back to port 0
    st_next.osc_auto = osc_code == OSC_AUTO; // [RL4]
    st_next.osc1 = osc_code == OSC_PORT1 ||
      (osc_code == OSC_AUTO && st_reg.long_flag);
    st_next.osc0 = !st_next.osc1;
    // Standard decode
    st_next.std = std_code; // [RL5]
    st_next.std_ok = 1'b1;
    if (std_code == STD_AUTO) begin
      st_next.std = st_reg.long_flag ? STD_PAL_BDGHI : STD_NTSC_M; // [RL6]
    end else if (std_code == STD_PAL_NCOMB) begin
      st_next.std_ok = ENHANCED; // [RL7]
    end
    // Window values for the field now running
    st_next.vstart = {st_reg.upper[fi][VS_UP_LSB +: 2],
      st_reg.vs_lo[fi]}; // [RL14] [RL18]
    st_next.vlines = {st_reg.upper[fi][VL_UP_LSB +: 2],
      st_reg.vl_lo[fi]}; // [RL15]
    st_next.hstart = {st_reg.upper[fi][HS_UP_LSB +: 2], st_reg.hs_lo[fi]};
    st_next.hpixels = {st_reg.upper[fi][HP_UP_LSB +: 2], st_reg.hp_lo[fi]};
    st_next.active = pixel_strobe_i && st_reg.pix_cnt >= st_reg.hstart
      && {1'b0, st_reg.pix_cnt} < win_end; // [RL17]
    if (reset_i) begin
      st_next = '0;
      st_next.src_std = RST_SRC_STD;
      st_next.drop_ctl = RST_DROP;
      st_next.upper = {2{RST_UPPER}};
      st_next.vs_lo = {2{RST_VSTART_LO}};
      st_next.vl_lo = {2{RST_VLINES_LO}};
      st_next.hs_lo = {2{RST_HSTART_LO}};
      st_next.hp_lo = {2{RST_HPIXELS_LO}};
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Drop scheduling
  // ----------------------------------------------------------------
  assign dsi.unit_tick = st_reg.tick;
  assign dsi.field_even = field_i;
  assign dsi.frame_mode = !st_reg.drop_ctl[DROP_UNIT_BIT]; // [RL8]
  assign dsi.first_even = st_reg.drop_ctl[DROP_PHASE_BIT]; // [RL9]
  assign dsi.count = st_reg.drop_ctl[DROP_COUNT_LSB +: 6]; // [RL10]
  assign dsi.long_format = st_reg.long_flag;

  drop_scheduler u_sched (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .dsi(dsi.sched)
  );

  // Outputs straight from the state flops
  assign reg_rdata_o = st_reg.rdata;
  assign selected_video_out_o = st_reg.src_idx;
  assign source_valid_o = st_reg.src_ok;
  assign oscillator_port_0_o = st_reg.osc0;
  assign oscillator_port_1_o = st_reg.osc1;
  assign oscillator_auto_o = st_reg.osc_auto;
  assign standard_o = st_reg.std;
  assign standard_valid_o = st_reg.std_ok;
  assign line_count_flag_o = st_reg.long_flag;
  assign drop_field_o = dsi.drop;
  assign vertical_start_offset_o = st_reg.vstart;
  assign vertical_line_count_o = st_reg.vlines;
  assign horizontal_start_offset_o = st_reg.hstart;
  assign horizontal_pixel_count_o = st_reg.hpixels;
  assign active_pixel_o = st_reg.active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_odd_upper_write;
    reg_write_i && reg_byte_en_i[0] && word == OFS_O_UPPER[11:2];
  endsequence

  chk_swap_write: assert property ( // [RL13]
    s_odd_upper_write |=> st_reg.upper[EVEN_IX][7:6] == $past(wd[7:6])
    ##1 st_reg.upper[ODD_IX][5:0] == $past(wd[5:0], 2))
    else $error("upper bits swap broken");
  chk_lane_zero: assert property ( // [RL20]
    reg_read_i |=> reg_rdata_o[31:8] == '0)
    else $error("upper lanes not zero");
  chk_auto_std: assert property ( // [RL6]
    std_code == STD_AUTO |=>
    standard_o == ($past(st_reg.long_flag) ? STD_PAL_BDGHI : STD_NTSC_M))
    else $error("auto standard wrong");
  chk_src_in2: assert property ( // [RL2]
    src_code == SRC_IN2 |=> selected_video_out_o == 2'h2)
    else $error("source code 01 wrong");
  chk_osc_auto: assert property ( // [RL4]
    osc_code == OSC_AUTO |=> oscillator_auto_o)
    else $error("oscillator auto missing");
  chk_flag_run: assert property ( // [RL19]
    $changed(line_count_flag_o) |-> $past(st_reg.run) == RUN_LAST)
    else $error("flag moved early");
  chk_field_copy: assert property ( // [RL18]
    !field_i |=> horizontal_start_offset_o ==
    {$past(st_reg.upper[ODD_IX][3:2]), $past(st_reg.hs_lo[ODD_IX])})
    else $error("odd copy not used");
  chk_window: assert property ( // [RL17]
    active_pixel_o |-> $past(pixel_strobe_i) &&
    $past(st_reg.pix_cnt) >= $past(st_reg.hstart))
    else $error("pixel outside window");
endmodule // capture_cfg_regs

//--- host_bus_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host driver model: byte-wide register accesses on lane 0
// ----------------------------------------------------------------
module host_bus_model (
  input wire logic clk_i,
  input wire logic [31:0] reg_rdata_i,
  output logic reg_write_o,
  output logic reg_read_o,
  output logic [11:0] reg_addr_o,
  output logic [3:0] reg_byte_en_o,
  output logic [31:0] reg_wdata_o
);
  import capture_cfg_pkg::*;

  // Idle bus at time zero
  initial begin
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
    reg_addr_o = 12'h000;
    reg_byte_en_o = 4'h0;
    reg_wdata_o = 32'h0;
  end

  // Write strobe held one full cycle, launched off the falling edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] be);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_byte_en_o = be;
    reg_wdata_o = {24'h0, (a == OFS_SRC_STD) ? (d & 8'h7F) : d};
    reg_write_o = 1'b1;
    @(negedge clk_i);
    reg_write_o = 1'b0;
    reg_wdata_o = ~reg_wdata_o; // Stale data must not look valid
  endtask

  // Read answer stands one cycle after the taking edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_byte_en_o = 4'hF; // Upper lanes on, so they must read as zero
    reg_read_o = 1'b1;
    @(negedge clk_i);
    reg_read_o = 1'b0;
    d = reg_rdata_i;
    reg_addr_o = ~a;
  endtask
endmodule // host_bus_model

//--- video_input_format_window_upper_bits_regs_bench.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
  end
module video_input_format_window_upper_bits_regs_bench;
  import capture_cfg_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] rst, w, back;} row_t;
  typedef struct {logic [7:0] cfg; int nf; logic [7:0] exp;} drop_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic field_i = 1'b0;
  logic vert_strobe_i = 1'b0;
  logic horiz_strobe_i = 1'b0;
  logic pixel_strobe_i = 1'b0;
  logic reg_write, reg_read;
  logic [11:0] reg_addr;
  logic [3:0] reg_byte_en;
  logic [31:0] reg_wdata, reg_rdata, rd_data;
  logic [1:0] sel;
  logic src_ok, osc0, osc1, osc_auto, std_ok, flag, drop, act_pix;
  logic [2:0] std;
  logic [9:0] vs, vl, hs, hp;
  logic [2:0] osc_bits;
  logic [39:0] win_bits;
  logic last_drop, prev;
  logic [7:0] act, n_drop, n_par, n_pair;
  int mismatches = 0;
  int n_compared = 0;
  // Readback table: reset value, value written, value expected back
  row_t rows [13] = '{'{OFS_SRC_STD, 8'h58, 8'hD8, 8'h58},
    '{OFS_DROP, 8'h00, 8'hC5, 8'hC5}, '{OFS_E_UPPER, 8'h12, 8'h12, 8'h12},
    '{OFS_O_UPPER, 8'h12, 8'h12, 8'h12}, '{OFS_E_VSTART, 8'h16, 8'h11, 8'h11},
    '{OFS_E_VLINES, 8'hE0, 8'h22, 8'h22}, '{OFS_E_HSTART, 8'h78, 8'h33, 8'h33},
    '{OFS_E_HPIXELS, 8'h80, 8'h44, 8'h44}, '{OFS_O_VSTART, 8'h16, 8'h55, 8'h55},
    '{OFS_O_VLINES, 8'hE0, 8'h66, 8'h66}, '{OFS_O_HSTART, 8'h78, 8'h77, 8'h77},
    '{OFS_O_HPIXELS, 8'h80, 8'h88, 8'h88}, '{12'h0FC, 8'h00, 8'hFF, 8'h00}};
  logic [1:0] src_map [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  logic [2:0] osc_exp [4] = '{3'b100, 3'b100, 3'b010, 3'b101};
  logic [39:0] win_exp [2] = '{{10'h155, 10'h066, 10'h277, 10'h388},
    {10'h211, 10'h022, 10'h033, 10'h044}};
  drop_t drops [4] = '{'{8'h80, 20, 8'd0}, '{8'h9E, 60, 8'd30},
    '{8'hDE, 60, 8'd30}, '{8'h0F, 120, 8'd30}};

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #4 clk_i = ~clk_i;
  assign osc_bits = {osc0, osc1, osc_auto};
  assign win_bits = {vs, vl, hs, hp};

  capture_cfg_regs dut (.clk_i(clk_i), .reset_i(reset_i),
    .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_addr_i(reg_addr),
    .reg_byte_en_i(reg_byte_en), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .field_i(field_i),
    .vert_strobe_i(vert_strobe_i), .horiz_strobe_i(horiz_strobe_i),
    .pixel_strobe_i(pixel_strobe_i), .selected_video_out_o(sel),
    .source_valid_o(src_ok), .oscillator_port_0_o(osc0),
    .oscillator_port_1_o(osc1), .oscillator_auto_o(osc_auto),
    .standard_o(std), .standard_valid_o(std_ok),
    .line_count_flag_o(flag), .drop_field_o(drop),
    .vertical_start_offset_o(vs), .vertical_line_count_o(vl),
    .horizontal_start_offset_o(hs), .horizontal_pixel_count_o(hp),
    .active_pixel_o(act_pix));

  host_bus_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata),
    .reg_write_o(reg_write), .reg_read_o(reg_read), .reg_addr_o(reg_addr),
    .reg_byte_en_o(reg_byte_en), .reg_wdata_o(reg_wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One field: strobe fall starts it, nl lines, drop sampled late
  task automatic fld(input logic par, input int nl);
    field_i = par;
    vert_strobe_i = 1'b1;
    @(negedge clk_i);
    vert_strobe_i = 1'b0;
    repeat (nl) begin
      horiz_strobe_i = 1'b1;
      @(negedge clk_i);
      horiz_strobe_i = 1'b0;
      @(negedge clk_i);
    end
    repeat (3) @(negedge clk_i);
    last_drop = drop;
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: a hang counts against the run
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    foreach (rows[i]) begin
      host.rd(rows[i].a, rd_data);
      `CHK(rd_data, 32'(rows[i].rst))
      host.wr(rows[i].a, rows[i].w, 4'h1);
      host.rd(rows[i].a, rd_data);
      `CHK(rd_data, 32'(rows[i].back))
    end
    // Decode of every source, oscillator and standard code
    for (int s = 0; s < 4; s++) begin
      host.wr(OFS_SRC_STD, {1'b0, 2'(s), 5'h09}, 4'h1);
      repeat (3) @(negedge clk_i);
      `CHK(sel, src_map[s])
      `CHK(src_ok, 1'b1)
    end
    for (int o = 0; o < 4; o++) begin
      host.wr(OFS_SRC_STD, {3'h2, 2'(o), 3'h1}, 4'h1);
      repeat (3) @(negedge clk_i);
      `CHK(osc_bits, osc_exp[o])
    end
    for (int d = 0; d < 8; d++) begin
      host.wr(OFS_SRC_STD, 8'h58 | 8'(d), 4'h1);
      repeat (3) @(negedge clk_i);
      `CHK(std, (d == 0) ? STD_NTSC_M : 3'(d))
      `CHK(std_ok, 1'b1)
    end
    // Upper bits with the swapped vertical start address
    host.wr(OFS_E_UPPER, 8'h40, 4'h1);
    host.wr(OFS_O_UPPER, 8'h8B, 4'h1);
    host.rd(OFS_E_UPPER, rd_data);
    `CHK(rd_data, 32'h40)
    host.rd(OFS_O_UPPER, rd_data);
    `CHK(rd_data, 32'h8B)
    host.wr(OFS_E_VSTART, 8'hAA, 4'h2);
    host.rd(OFS_E_VSTART, rd_data);
    `CHK(rd_data, 32'h11)
    for (int f = 0; f < 2; f++) begin
      field_i = f[0];
      repeat (3) @(negedge clk_i);
      `CHK(win_bits, win_exp[f])
    end
    // Pixel window, including one that runs past the line's end
    for (int t = 0; t < 2; t++) begin
      host.wr(OFS_E_HSTART, (t == 0) ? 8'h03 : 8'h0A, 4'h1);
      host.wr(OFS_E_HPIXELS, 8'h04, 4'h1);
      repeat (3) @(negedge clk_i);
      horiz_strobe_i = 1'b1;
      @(negedge clk_i);
      horiz_strobe_i = 1'b0;
      @(negedge clk_i);
      act = 8'd0;
      repeat (12) begin
        pixel_strobe_i = 1'b1;
        @(negedge clk_i);
        pixel_strobe_i = 1'b0;
        act = act + 8'(act_pix);
        @(negedge clk_i);
        act = act + 8'(act_pix);
      end
      `CHK(act, (t == 0) ? 8'd4 : 8'd2)
    end
    // Decimation: off, by fields at both phases, by frames
    foreach (drops[i]) begin
      host.wr(OFS_DROP, 8'h00, 4'h1);
      fld(1'b1, 2); // Zero-count field clears the previous row's phase
      host.wr(OFS_DROP, drops[i].cfg, 4'h1);
      n_drop = 8'd0;
      n_par = 8'd0;
      n_pair = 8'd0;
      prev = 1'b0;
      for (int k = 0; k < drops[i].nf; k++) begin
        fld(k[0], 2);
        n_drop = n_drop + 8'(last_drop);
        n_par = n_par + 8'(last_drop && k[0] == drops[i].cfg[6]);
        n_pair = n_pair + 8'(last_drop && prev);
        prev = last_drop;
      end
      `CHK(n_drop, drops[i].exp)
      if (drops[i].cfg[7]) begin
        `CHK(n_par, drops[i].exp)
        `CHK(n_pair, 8'd0)
      end else begin
        `CHK(n_pair, drops[i].exp >> 1)
      end
    end
    // Line-count flag needs 32 long fields; auto modes follow it
    host.wr(OFS_DROP, 8'h00, 4'h1);
    host.wr(OFS_SRC_STD, 8'h18, 4'h1);
    for (int k = 0; k < 32; k++) fld(k[0], 290);
    `CHK(flag, 1'b0)
    fld(1'b0, 290);
    `CHK(flag, 1'b1)
    `CHK(std, STD_PAL_BDGHI)
    `CHK(osc_bits, 3'b011)
    // Second reset mid-run restores the register
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    host.rd(OFS_SRC_STD, rd_data);
    `CHK(rd_data, 32'h58)
    `CHK(flag, 1'b0)
    close_out();
  end
endmodule // video_input_format_window_upper_bits_regs_bench
